// *** hdl/dac_cmd_defines.vh ***
// constants for the octal converter command decoder
`ifndef DAC_CMD_DEFINES_VH
`define DAC_CMD_DEFINES_VH
`define CMD_WIDTH        16
`define CODE_WIDTH       12
`define NUM_CHAN         8
`define OP_REG_ONLY      4'h8
`define OP_WRITE_THRU    4'h9
`define OP_UPDATE_SEL    4'ha
`define OP_CHAN_A_WRITE  4'hb
`define OP_BROADCAST     4'hc
`define OP_PD_HIZ        4'hd
`define OP_PD_100K       4'he
`define OP_PD_2K5        4'hf
`define TERM_NONE        2'h0
`define TERM_HIZ         2'h1
`define TERM_100K        2'h2
`define TERM_2K5         2'h3
`define CLK_PERIOD_NS    50
`define WAKE_3V_NS       3000
`define WAKE_5V_NS       20000
`define WAKE_3V_CYC      ((`WAKE_3V_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WAKE_5V_CYC      ((`WAKE_5V_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ADDR_MODE        8'h00
`define ADDR_PD          8'h04
`define ADDR_WAKE        8'h08
`define ADDR_CMD         8'h0c
`define ADDR_DATA0       8'h20
`define ADDR_OUT0        8'h40
`define ADDR_CFG         8'h60
`define HTRANS_NONSEQ    2'h2
`endif

// *** hdl/bit_sync.v ***
// two-flop synchroniser for pin inputs
module bit_sync (
    input  wire hclk,
    input  wire hresetn,
    input  wire d,
    output wire q
);
    reg meta_reg;
    reg sync_reg;
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
        end else begin
            meta_reg <= d;
            sync_reg <= meta_reg;
        end
    end
    assign q = sync_reg;
endmodule // bit_sync

// *** hdl/serial_shifter.v ***
// sixteen-bit serial command receiver sampled on the system clock
`include "dac_cmd_defines.vh"
module serial_shifter (
    input  wire                    hclk,
    input  wire                    hresetn,
    input  wire                    sclk_s,
    input  wire                    frame_select_n_s,
    input  wire                    sdi_s,
    output reg  [`CMD_WIDTH-1:0]   word_reg,
    output reg                     word_valid_reg
);
    reg  [`CMD_WIDTH-1:0] shift_reg;
    reg  [4:0]            count_reg;
    reg                   sclk_d_reg;
    wire                  fall;
    // data is taken on the falling edge of the link clock
    assign fall = sclk_d_reg & ~sclk_s;
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            shift_reg      <= 16'h0000;
            count_reg      <= 5'h00;
            sclk_d_reg     <= 1'b0;
            word_reg       <= 16'h0000;
            word_valid_reg <= 1'b0;
        end else begin
            sclk_d_reg     <= sclk_s;
            word_valid_reg <= 1'b0;
            if (frame_select_n_s) begin
                count_reg <= 5'h00;
            end else if (fall && count_reg < 5'd16) begin
                shift_reg <= {shift_reg[14:0], sdi_s};
                count_reg <= count_reg + 5'd1;
                if (count_reg == 5'd15) begin
                    word_reg       <= {shift_reg[14:0], sdi_s};
                    word_valid_reg <= 1'b1;
                end
            end
        end
    end
endmodule // serial_shifter

// *** hdl/octal_dac_command_powerdown.v ***
// command decoder, channel registers and power-down control of the octal converter
//
// Our own choices: the AHB-Lite register port and the register addresses.
`include "dac_cmd_defines.vh"
module octal_dac_command_powerdown (
    input  wire         hclk,
    input  wire         hresetn,
    input  wire         hsel,
    input  wire [31:0]  haddr,
    input  wire [1:0]   htrans,
    input  wire         hwrite,
    input  wire [2:0]   hsize,
    input  wire [31:0]  hwdata,
    input  wire         hready,
    output reg  [31:0]  hrdata,
    output wire         hreadyout,
    output wire         hresp,
    input  wire         sclk,
    input  wire         frame_select_n,
    input  wire         serial_data_in,
    output wire [95:0]  dac_out_codes,
    output wire [7:0]   amp_enable,
    output wire [15:0]  out_termination,
    output wire         bias_enable,
    output wire [7:0]   wake_busy
);
    wire                  sclk_s;
    wire                  fs_s;
    wire                  sdi_s;
    wire [15:0]           word;
    wire                  word_valid;
    wire [3:0]            op;
    wire [2:0]            ch;
    wire [11:0]           code;
    localparam [1:0]      MODE_REG_ONLY   = 2'b01;
    localparam [1:0]      MODE_WRITE_THRU = 2'b10;
    reg  [1:0]            mode_reg;
    reg  [1:0]            mode_next;
    wire                  write_through;
    reg                   supply_5v_reg;
    reg  [11:0]           data_reg [0:7];
    reg  [11:0]           out_reg  [0:7];
    reg  [1:0]            term_reg [0:7];
    reg  [10:0]           wake_cnt_reg [0:7];
    reg  [15:0]           last_cmd_reg;
    reg                   ph_valid_reg;
    reg                   ph_write_reg;
    reg  [7:0]            ph_addr_reg;
    wire [10:0]           wake_load;
    wire                  addr_phase;
    wire [7:0]            pd_bits;
    wire [7:0]            pd_mask;
    wire [7:0]            chan_sel;
    wire [1:0]            pd_term;
    wire                  is_chan_wr;
    wire                  is_reg_only;
    wire                  is_write_thr;
    wire                  is_upd_sel;
    wire                  is_chan_a;
    wire                  is_bcast;
    wire                  is_pd;
    wire [31:0]           wake_5v_full;
    wire [31:0]           wake_3v_full;
    wire                  rd_data_win;
    wire                  rd_out_win;
    wire                  rd_term_win;
    wire [2:0]            rd_index;

    bit_sync u_sync_sclk (.hclk(hclk), .hresetn(hresetn), .d(sclk),           .q(sclk_s));
    bit_sync u_sync_fs   (.hclk(hclk), .hresetn(hresetn), .d(frame_select_n), .q(fs_s));
    bit_sync u_sync_sdi  (.hclk(hclk), .hresetn(hresetn), .d(serial_data_in), .q(sdi_s));

    serial_shifter u_shift (
        .hclk             (hclk),
        .hresetn          (hresetn),
        .sclk_s           (sclk_s),
        .frame_select_n_s (fs_s),
        .sdi_s            (sdi_s),
        .word_reg         (word),
        .word_valid_reg   (word_valid)
    );

    // command fields
    assign op       = word[15:12];
    assign ch       = word[14:12];
    assign code     = word[11:0];
    assign pd_mask  = word[7:0];
    assign pd_term  = op[1:0];
    assign chan_sel = 8'h01 << ch;

    // one strobe per command kind, each lasting the single cycle of word_valid
    assign is_chan_wr   = word_valid && !word[15];
    assign is_reg_only  = word_valid && (op == `OP_REG_ONLY);
    assign is_write_thr = word_valid && (op == `OP_WRITE_THRU);
    assign is_upd_sel   = word_valid && (op == `OP_UPDATE_SEL);
    assign is_chan_a    = word_valid && (op == `OP_CHAN_A_WRITE);
    assign is_bcast     = word_valid && (op == `OP_BROADCAST);
    assign is_pd        = word_valid && ((op == `OP_PD_HIZ) || (op == `OP_PD_100K) || (op == `OP_PD_2K5));

    // wake counts are integer expressions, cut to the counter width on purpose
    assign wake_5v_full = `WAKE_5V_CYC;
    assign wake_3v_full = `WAKE_3V_CYC;
    assign wake_load    = supply_5v_reg ? wake_5v_full[10:0] : wake_3v_full[10:0];

    // address phase taken on a selected, ready NONSEQ cycle
    assign addr_phase = hsel & hready & (htrans == `HTRANS_NONSEQ);

    // operating mode, one-hot
    always @* begin
        mode_next = mode_reg;
        case (mode_reg)
            MODE_REG_ONLY: begin
                if (is_write_thr) begin
                    mode_next = MODE_WRITE_THRU;
                end
            end
            MODE_WRITE_THRU: begin
                if (is_reg_only) begin
                    mode_next = MODE_REG_ONLY;
                end
            end
            default: begin
                mode_next = MODE_REG_ONLY;
            end
        endcase
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mode_reg <= MODE_REG_ONLY;
        end else begin
            mode_reg <= mode_next;
        end
    end

    assign write_through = mode_reg[1];

    // last command word, kept for read-back
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            last_cmd_reg <= 16'h0000;
        end else if (word_valid) begin
            last_cmd_reg <= word;
        end
    end

    // per-channel registers and power state
    genvar i;
    generate
        for (i = 0; i < 8; i = i + 1) begin : g_chan
            wire chan_hit;
            wire pd_hit;
            wire wr_any;
            wire upd_any;
            wire waking;

            assign chan_hit = is_chan_wr && chan_sel[i];
            assign pd_hit   = is_pd && pd_mask[i];
            assign wr_any   = chan_hit || is_bcast || (is_chan_a && (i == 0));
            // outputs follow a channel write only in write-through mode
            assign upd_any  = (chan_hit && write_through) || is_bcast || is_chan_a ||
                              (is_upd_sel && pd_mask[i]);
            // a down channel wakes whenever its output is refreshed
            assign waking   = (term_reg[i] != `TERM_NONE) && upd_any;

            // power-down commands never reach the data register
            always @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    data_reg[i] <= 12'h000;
                end else if (wr_any) begin
                    data_reg[i] <= code;
                end
            end

            always @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    out_reg[i] <= 12'h000;
                end else if (upd_any && wr_any) begin
                    out_reg[i] <= code;
                end else if (upd_any) begin
                    out_reg[i] <= data_reg[i];
                end
            end

            always @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    term_reg[i] <= `TERM_NONE;
                end else if (pd_hit) begin
                    term_reg[i] <= pd_term;
                end else if (waking) begin
                    term_reg[i] <= `TERM_NONE;
                end
            end

            // wake interval restarts on each recovery, cleared by a new power-down
            always @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    wake_cnt_reg[i] <= 11'h000;
                end else if (pd_hit) begin
                    wake_cnt_reg[i] <= 11'h000;
                end else if (waking) begin
                    wake_cnt_reg[i] <= wake_load;
                end else if (wake_cnt_reg[i] != 11'h000) begin
                    wake_cnt_reg[i] <= wake_cnt_reg[i] - 11'd1;
                end
            end

            assign pd_bits[i]                  = (term_reg[i] != `TERM_NONE);
            assign amp_enable[i]               = ~pd_bits[i];
            assign out_termination[2*i+1:2*i]  = term_reg[i];
            assign dac_out_codes[12*i+11:12*i] = out_reg[i];
            assign wake_busy[i]                = (wake_cnt_reg[i] != 11'h000);
        end
    endgenerate

    // shared bias stays up while any channel is active
    assign bias_enable = ~&pd_bits;

    // ahb-lite slave, zero wait states
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    // address phase held over for the data phase of a write
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ph_valid_reg <= 1'b0;
            ph_write_reg <= 1'b0;
            ph_addr_reg  <= 8'h00;
        end else begin
            ph_valid_reg <= addr_phase;
            ph_write_reg <= hwrite;
            ph_addr_reg  <= haddr[7:0];
        end
    end

    // supply select, written in the data phase of a cfg write
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            supply_5v_reg <= 1'b0;
        end else if (ph_valid_reg && ph_write_reg && (ph_addr_reg == `ADDR_CFG)) begin
            supply_5v_reg <= hwdata[0];
        end
    end

    // data registers from 0x20, codes from 0x40, codes with termination from 0x50
    assign rd_index    = haddr[4:2];
    assign rd_data_win = (haddr[7:5] == 3'h1);
    assign rd_out_win  = (haddr[7:5] == 3'h2) && !haddr[4];
    assign rd_term_win = (haddr[7:5] == 3'h2) && haddr[4];

    // read data loaded at the address phase, stands through the data phase

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h00000000;
        end else if (addr_phase && !hwrite) begin
            case (haddr[7:0])
                `ADDR_MODE: hrdata <= {31'h0, write_through};
                `ADDR_PD:   hrdata <= {23'h0, bias_enable, pd_bits};
                `ADDR_WAKE: hrdata <= {24'h0, wake_busy};
                `ADDR_CMD:  hrdata <= {16'h0, last_cmd_reg};
                `ADDR_CFG:  hrdata <= {31'h0, supply_5v_reg};
                default: begin
                    if (rd_data_win) begin
                        hrdata <= {20'h0, data_reg[rd_index]};
                    end else if (rd_out_win) begin
                        hrdata <= {20'h0, out_reg[rd_index]};
                    end else if (rd_term_win) begin
                        hrdata <= {14'h0, term_reg[rd_index], 4'h0, out_reg[rd_index]};
                    end else begin
                        hrdata <= 32'h00000000;
                    end
                end
            endcase
        end
    end
endmodule // octal_dac_command_powerdown

// *** dv/dac_cmd_properties.sv ***
// assertion checker for the octal converter command decoder
module dac_cmd_properties (
    input wire        hclk,
    input wire        hresetn,
    input wire        hreadyout,
    input wire        hresp,
    input wire        frame_select_n,
    input wire [95:0] dac_out_codes,
    input wire [7:0]  amp_enable,
    input wire [15:0] out_termination,
    input wire        bias_enable,
    input wire [7:0]  wake_busy
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    reg [9:0] busy_cnt;
    always @(posedge hclk or negedge hresetn)
        if (!hresetn) busy_cnt <= 10'h0;
        else busy_cnt <= wake_busy[0] ? busy_cnt + 10'h1 : 10'h0;
    sequence frame_start; $fell(frame_select_n); endsequence
    sequence codes_held; $stable(dac_out_codes) [*8]; endsequence
    a_bias_any_up: assert property (bias_enable == |amp_enable)
        else $error("bias enable wrong");
    a_term_amp_off: assert property ((out_termination[1:0] != 2'h0) == !amp_enable[0])
        else $error("termination and amplifier disagree");
    a_reset_clear: assert property ($rose(hresetn) |-> dac_out_codes == 96'h0 && amp_enable == 8'hff)
        else $error("reset state wrong");
    a_wake_starts: assert property ($rose(amp_enable[0]) |-> ##[0:2] wake_busy[0])
        else $error("no wake interval");
    a_wake_bound: assert property (busy_cnt <= 10'h191)
        else $error("wake interval too long");
    a_busy_when_up: assert property (wake_busy[0] |-> amp_enable[0])
        else $error("busy while powered down");
    a_down_keeps_code: assert property ($fell(amp_enable[0]) |-> $stable(dac_out_codes[11:0]))
        else $error("code changed on power-down");
    a_frame_quiet: assert property (frame_start |-> codes_held)
        else $error("outputs changed early in frame");
    a_bus_okay: assert property (hreadyout && !hresp)
        else $error("bus not ready or error");
endmodule // dac_cmd_properties

bind octal_dac_command_powerdown dac_cmd_properties i_props (.hclk, .hresetn, .hreadyout, .hresp,
    .frame_select_n, .dac_out_codes, .amp_enable, .out_termination, .bias_enable, .wake_busy);

// *** dv/serial_host_model.sv ***
// serial host shifting command words into the converter
module serial_host_model (
    input  logic hclk,
    output logic sclk,
    output logic frame_select_n,
    output logic serial_data_in
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        sclk = 1'b0;
        frame_select_n = 1'b1;
        serial_data_in = 1'b0;
    end
    // one link clock period is eight system clocks, stopped between frames
    task automatic send(input logic [15:0] w);
        @(posedge hclk);
        frame_select_n <= 1'b0;
        for (int i = 15; i >= 0; i--) begin
            serial_data_in <= w[i];
            repeat (2) @(posedge hclk);
            sclk <= 1'b1;
            repeat (4) @(posedge hclk);
            sclk <= 1'b0;
            repeat (2) @(posedge hclk);
        end
        frame_select_n <= 1'b1;
        serial_data_in <= 1'b0;
        repeat (8) @(posedge hclk);
    endtask
endmodule // serial_host_model

// *** dv/octal_dac_command_powerdown_tb_top.sv ***
// self-checking bench for the octal converter command decoder
module octal_dac_command_powerdown_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel = 1'b0;
    logic        hwrite = 1'b0;
    logic [1:0]  htrans = 2'h0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    wire  [31:0] hrdata;
    wire         hreadyout, hresp, sclk, frame_select_n, serial_data_in, bias_enable;
    wire  [95:0] dac_out_codes;
    wire  [7:0]  amp_enable, wake_busy;
    wire  [15:0] out_termination;
    integer      num_errors = 0;
    integer      n_checks = 0;
    integer      seed = 24072;
    logic [11:0] reg_m [8] = '{default: 12'h0};
    logic [11:0] out_m [8] = '{default: 12'h0};
    logic [7:0]  down_m = 8'h0;
    logic [15:0] term_m = 16'h0;
    logic        wt_m = 1'b0;
    logic [7:0]  woke_m = 8'h0;
    logic [31:0] rv;
    logic [15:0] seq [20] = '{16'h0fff, 16'h1c00, 16'h2800, 16'h3400, 16'ha00f, 16'h9000, 16'h6800,
        16'h5fff, 16'h8000, 16'h3123, 16'hbfff, 16'hc7aa, 16'hdf03, 16'he0f0, 16'hf00c, 16'h0111,
        16'h9000, 16'h2555, 16'h8000, 16'ha001};
    always #25 hclk = ~hclk;
    serial_host_model i_host (.hclk, .sclk, .frame_select_n, .serial_data_in);
    octal_dac_command_powerdown i_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
        .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .sclk, .frame_select_n, .serial_data_in,
        .dac_out_codes, .amp_enable, .out_termination, .bias_enable, .wake_busy);
    task print_verdict;
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task check(input string what, input [95:0] seen, input [95:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task ahb(input w, input [31:0] a, input [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rv = hrdata;
    endtask
    function [95:0] exp_codes();
        for (int c = 0; c < 8; c++) exp_codes[12*c+:12] = out_m[c];
    endfunction
    task chk;
        check("codes", dac_out_codes, exp_codes());
        check("amp", amp_enable, 8'(~down_m));
        check("wake", wake_busy & (woke_m | down_m), woke_m);
        check("term", out_termination, term_m);
        check("bias", bias_enable, ~&down_m);
        ahb(1'b0, 32'h0, 32'h0);
        check("mode", rv[0], wt_m);
        for (int c = 0; c < 8; c++) begin
            ahb(1'b0, 32'h20 + 4 * c, 32'h0);
            check("data", rv[11:0], reg_m[c]);
        end
    endtask
    task wake(input int c);
        out_m[c] = reg_m[c];
        woke_m[c] = woke_m[c] | down_m[c];
        down_m[c] = 1'b0;
        term_m[2*c+:2] = 2'h0;
    endtask
    task cmd(input [15:0] w);
        woke_m = 8'h0;
        i_host.send(w);
        case (w[15:12])
            4'h8: wt_m = 1'b0;
            4'h9: wt_m = 1'b1;
            4'ha: for (int c = 0; c < 8; c++) if (w[c]) wake(c);
            4'hb: begin
                reg_m[0] = w[11:0];
                for (int c = 0; c < 8; c++) wake(c);
            end
            4'hc: for (int c = 0; c < 8; c++) begin
                reg_m[c] = w[11:0];
                wake(c);
            end
            4'hd, 4'he, 4'hf: for (int c = 0; c < 8; c++) if (w[c]) begin
                down_m[c] = 1'b1;
                term_m[2*c+:2] = w[13:12];
            end
            default: begin
                reg_m[w[14:12]] = w[11:0];
                if (wt_m) wake(w[14:12]);
            end
        endcase
        repeat (12) @(posedge hclk);
        chk;
    endtask
    initial begin
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        chk;
        ahb(1'b1, 32'h7c, 32'hffffffff);
        ahb(1'b0, 32'h7c, 32'h0);
        check("unmapped", rv, 32'h0);
        ahb(1'b1, 32'h60, 32'h1);
        ahb(1'b0, 32'h60, 32'h0);
        check("cfg", rv[0], 1'b1);
        foreach (seq[k]) cmd(seq[k]);
        repeat (16) cmd(16'($random(seed)));
        print_verdict;
    end
    initial begin
        #3000000;
        num_errors++;
        print_verdict;
    end
endmodule // octal_dac_command_powerdown_tb_top
